// ---- hw/mfps_pin_select.sv ----
// pin routing and strap result registers on the configuration port
`timescale 1ns/100ps
`default_nettype none
module mfps_pin_select #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8,
  parameter int STRAP_BITS = 3
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic power_ok_reset,
  input wire logic gpio_group5_reset,
  input wire logic alt_power_sequence_strap,
  input wire logic test_mode_strap,
  input wire logic input_clock_freq_strap,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic [7:0] pin_route_select_a,
  output logic [7:0] pin_route_select_b,
  output logic [7:0] pin_route_select_c,
  output logic [7:0] strap_result,
  output mfps_pkg::mfps_p30_t pin30_mode
);
  mfps_pkg::mfps_state_t st;
  mfps_pkg::mfps_state_t next_st;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_s;
  logic wr_any_reg;
  logic rd_unmapped;
  logic [2:0] strap_pins;

  if (DATA_W != 8 || ADDR_W != 8 || STRAP_BITS != 3) begin : g_bad_param
    $error("pin select supports only 8 bit data, 8 bit index and 3 straps");
  end

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction

  function automatic mfps_pkg::mfps_p30_t pin30_of(input logic route_bit, input logic alt_bit);
    if (route_bit) begin
      pin30_of = mfps_pkg::MFPS_P30_GPIO;
    end else if (alt_bit) begin
      pin30_of = mfps_pkg::MFPS_P30_ALT_SUPPLY_ON;
    end else begin
      pin30_of = mfps_pkg::MFPS_P30_SUPPLY_ON;
    end
  endfunction

  function automatic logic [7:0] wmask_of(input logic [7:0] a);
    case (a)
      mfps_pkg::ADDR_ROUTE_A: wmask_of = mfps_pkg::WMASK_ROUTE_A;
      mfps_pkg::ADDR_ROUTE_B: wmask_of = mfps_pkg::WMASK_ROUTE_B;
      mfps_pkg::ADDR_ROUTE_C: wmask_of = mfps_pkg::WMASK_ROUTE_C;
      mfps_pkg::ADDR_STRAP: wmask_of = mfps_pkg::WMASK_STRAP;
      default: wmask_of = 8'h00;
    endcase
  endfunction

  assign hit_a = addr_is(cfg_addr, mfps_pkg::ADDR_ROUTE_A);
  assign hit_b = addr_is(cfg_addr, mfps_pkg::ADDR_ROUTE_B);
  assign hit_c = addr_is(cfg_addr, mfps_pkg::ADDR_ROUTE_C);
  assign hit_s = addr_is(cfg_addr, mfps_pkg::ADDR_STRAP);
  assign wr_any_reg = cfg_wr && (wmask_of(cfg_addr) != 8'h00);
  assign rd_unmapped = cfg_rd && !(hit_a || hit_b || hit_c || hit_s);
  assign strap_pins = {alt_power_sequence_strap, test_mode_strap, input_clock_freq_strap};

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction

  always_comb begin
    next_st = st;
    if (cfg_wr) begin
      case (cfg_addr)
        mfps_pkg::ADDR_ROUTE_A: begin
          next_st.route_a = merge(st.route_a, cfg_wdata, mfps_pkg::WMASK_ROUTE_A);
        end
        mfps_pkg::ADDR_ROUTE_B: begin
          next_st.route_b = mfps_pkg::FIXED_ROUTE_B
                            | (cfg_wdata & mfps_pkg::WMASK_ROUTE_B);
        end
        mfps_pkg::ADDR_ROUTE_C: begin
          next_st.route_c = merge(st.route_c, cfg_wdata, mfps_pkg::WMASK_ROUTE_C);
        end
        mfps_pkg::ADDR_STRAP: begin
          next_st.strap = merge(st.strap, cfg_wdata, mfps_pkg::WMASK_STRAP);
        end
        default: begin
        end
      endcase
    end
    if (gpio_group5_reset) begin
      next_st.route_c = next_st.route_c & ~mfps_pkg::G5_MASK_ROUTE_C;
    end
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.strap[mfps_pkg::BIT_ALT_STRAP] = alt_power_sequence_strap;
      next_st.strap[mfps_pkg::BIT_TEST_STRAP] = test_mode_strap;
      next_st.strap[mfps_pkg::BIT_CLK_STRAP] = input_clock_freq_strap;
    end
    if (power_ok_reset) begin
      next_st.strap[mfps_pkg::BIT_TEST_STRAP] = test_mode_strap;
      next_st.strap[mfps_pkg::BIT_CLK_STRAP] = input_clock_freq_strap;
    end
    next_st.pin30 = pin30_of(next_st.route_c[mfps_pkg::BIT_PIN30],
                             next_st.strap[mfps_pkg::BIT_ALT_STRAP]);
    if (cfg_rd) begin
      case (cfg_addr)
        mfps_pkg::ADDR_ROUTE_A: next_st.rdata = st.route_a;
        mfps_pkg::ADDR_ROUTE_B: next_st.rdata = st.route_b;
        mfps_pkg::ADDR_ROUTE_C: next_st.rdata = st.route_c;
        mfps_pkg::ADDR_STRAP: next_st.rdata = st.strap;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st.route_a <= mfps_pkg::RST_ROUTE_A;
      st.route_b <= mfps_pkg::RST_ROUTE_B;
      st.route_c <= mfps_pkg::RST_ROUTE_C;
      st.strap <= mfps_pkg::RST_STRAP;
      st.strap_done <= 1'b0;
      st.rdata <= 8'h00;
      st.pin30 <= mfps_pkg::MFPS_P30_SUPPLY_ON;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata = st.rdata;
  assign pin_route_select_a = st.route_a;
  assign pin_route_select_b = st.route_b;
  assign pin_route_select_c = st.route_c;
  assign strap_result = st.strap;
  assign pin30_mode = st.pin30;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_route_a_resv: assert property (st.route_a[7] == 1'b0 && st.route_a[1] == 1'b0)
    else $error("route a reserved bit set");
  a_route_a_write: assert property (cfg_wr && cfg_addr == mfps_pkg::ADDR_ROUTE_A
    |=> st.route_a == ($past(cfg_wdata) & mfps_pkg::WMASK_ROUTE_A))
    else $error("route a write lost");
  a_route_b_fixed: assert property (st.route_b[7:1] == 7'h40)
    else $error("route b fixed bits wrong");
  a_route_c_g5: assert property (gpio_group5_reset |=> st.route_c[4:1] == 4'h0)
    else $error("group5 reset missed");
  a_route_c_resv: assert property ((st.route_c & ~mfps_pkg::WMASK_ROUTE_C) == 8'h00)
    else $error("route c reserved bit set");
  a_pin30_mode: assert property (##1 pin30_mode == (st.route_c[2] ? mfps_pkg::MFPS_P30_GPIO :
    (st.strap[5] ? mfps_pkg::MFPS_P30_ALT_SUPPLY_ON : mfps_pkg::MFPS_P30_SUPPLY_ON)))
    else $error("pin30 mode mismatch");
  a_strap_read: assert property (cfg_rd && cfg_addr == mfps_pkg::ADDR_STRAP
    |=> cfg_rdata == $past(st.strap))
    else $error("strap read wrong");
  a_strap_pok: assert property (power_ok_reset && !(cfg_wr && cfg_addr == mfps_pkg::ADDR_STRAP)
    |=> st.strap[1:0] == $past({test_mode_strap, input_clock_freq_strap}))
    else $error("power ok reload missed");
  a_strap_hold: assert property (st.strap_done && !power_ok_reset && !cfg_wr
    |=> st.strap == $past(st.strap))
    else $error("strap result changed");
  a_strap_resv: assert property (st.strap[7:6] == 2'b00 && st.strap[4:2] == 3'b000)
    else $error("strap reserved bit set");
  a_unmapped_rd: assert property (cfg_rd && cfg_addr[7:4] != 4'h2 |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // write path checks
  a_route_b_write: assert property (cfg_wr && hit_b
    |=> st.route_b == (mfps_pkg::FIXED_ROUTE_B | ($past(cfg_wdata) & mfps_pkg::WMASK_ROUTE_B)))
    else $error("route b write lost");

  a_route_c_write: assert property (cfg_wr && hit_c && !gpio_group5_reset
    |=> st.route_c == ($past(cfg_wdata) & mfps_pkg::WMASK_ROUTE_C))
    else $error("route c write lost");

  a_g5_beats_wr: assert property (cfg_wr && hit_c && gpio_group5_reset
    |=> st.route_c == ($past(cfg_wdata) & 8'h40))
    else $error("group5 reset lost to write");

  a_strap_write: assert property (cfg_wr && hit_s && st.strap_done && !power_ok_reset
    |=> st.strap == ($past(cfg_wdata) & mfps_pkg::WMASK_STRAP))
    else $error("strap write lost");

  a_strap_wr_pok: assert property (cfg_wr && hit_s && st.strap_done && power_ok_reset
    |=> st.strap[5] == $past(cfg_wdata[5]))
    else $error("standby strap write lost");

  a_pok_beats_wr: assert property (cfg_wr && hit_s && st.strap_done && power_ok_reset
    |=> st.strap[1:0] == $past(strap_pins[1:0]))
    else $error("power ok reload lost to write");

  a_unmapped_wr: assert property (cfg_wr && !wr_any_reg && !gpio_group5_reset
    && !power_ok_reset && st.strap_done
    |=> $stable({st.route_a, st.route_b, st.route_c, st.strap}))
    else $error("unmapped write changed a register");

  // strap capture and hold
  a_strap_capture: assert property (!st.strap_done
    |=> st.strap_done && {st.strap[5], st.strap[1:0]} == $past(strap_pins))
    else $error("strap capture wrong");

  a_done_stays: assert property (st.strap_done |=> st.strap_done)
    else $error("strap capture repeated");

  a_strap_keep5: assert property (st.strap_done && !(cfg_wr && hit_s)
    |=> st.strap[5] == $past(st.strap[5]))
    else $error("standby strap changed");

  // hold checks
  a_route_a_hold: assert property (!(cfg_wr && hit_a) |=> $stable(st.route_a))
    else $error("route a changed");

  a_route_b_hold: assert property (!(cfg_wr && hit_b) |=> $stable(st.route_b))
    else $error("route b changed");

  a_route_c_hold: assert property (!(cfg_wr && hit_c) && !gpio_group5_reset
    |=> $stable(st.route_c))
    else $error("route c changed");

  a_g5_no_other: assert property (gpio_group5_reset && !cfg_wr
    |=> st.route_c[6] == $past(st.route_c[6]))
    else $error("group5 reset hit bit 6");

  a_read_no_side: assert property (cfg_rd && !cfg_wr
    |=> $stable({st.route_a, st.route_b}))
    else $error("read changed a register");

  // read path checks, then pin30 legality and per-bit write checks
  a_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved");

  a_read_a: assert property (cfg_rd && hit_a |=> cfg_rdata == $past(st.route_a))
    else $error("route a read wrong");

  a_read_b: assert property (cfg_rd && hit_b |=> cfg_rdata == $past(st.route_b))
    else $error("route b read wrong");

  a_read_c: assert property (cfg_rd && hit_c |=> cfg_rdata == $past(st.route_c))
    else $error("route c read wrong");

  a_test_read: assert property (cfg_rd && hit_s |=> cfg_rdata[1] == $past(st.strap[1]))
    else $error("test strap read wrong");

  a_clk_read: assert property (cfg_rd && hit_s |=> cfg_rdata[0] == $past(st.strap[0]))
    else $error("clock strap read wrong");

  a_unmapped_zero: assert property (rd_unmapped |=> cfg_rdata == 8'h00)
    else $error("unmapped index read not zero");

  a_pin30_legal: assert property (pin30_mode inside {mfps_pkg::MFPS_P30_SUPPLY_ON,
    mfps_pkg::MFPS_P30_ALT_SUPPLY_ON, mfps_pkg::MFPS_P30_GPIO})
    else $error("pin30 mode illegal");

  for (genvar b = 0; b < 8; b++) begin : g_a_bit
    if (mfps_pkg::WMASK_ROUTE_A[b]) begin : g_live
      a_route_a_bit: assert property (cfg_wr && hit_a |=> st.route_a[b] == $past(cfg_wdata[b]))
        else $error("route a bit write lost");
    end else begin : g_resv
      a_route_a_zero: assert property (cfg_wr && hit_a |=> st.route_a[b] == 1'b0)
        else $error("route a reserved bit written");
    end
  end

  for (genvar b = 0; b < 8; b++) begin : g_c_bit
    if (mfps_pkg::WMASK_ROUTE_C[b]) begin : g_live
      a_route_c_bit: assert property (cfg_wr && hit_c && !gpio_group5_reset
        |=> st.route_c[b] == $past(cfg_wdata[b]))
        else $error("route c bit write lost");
    end else begin : g_resv
      a_route_c_zero: assert property (cfg_wr && hit_c |=> st.route_c[b] == 1'b0)
        else $error("route c reserved bit written");
    end
  end
  c_write_a: cover property (cfg_wr && cfg_addr == mfps_pkg::ADDR_ROUTE_A && cfg_wdata[6]);
  c_alt_supply: cover property (pin30_mode == mfps_pkg::MFPS_P30_ALT_SUPPLY_ON);
  c_strap_write: cover property (cfg_wr && cfg_addr == mfps_pkg::ADDR_STRAP ##1 power_ok_reset);
  c_g5_clear: cover property (gpio_group5_reset && st.route_c[4:1] != 4'h0);
  c_unmapped_read: cover property (rd_unmapped);
endmodule
`default_nettype wire

// ---- hw/mfps_pkg.sv ----
// constants and types for the multi-function pin select registers
package mfps_pkg;
  localparam logic [7:0] ADDR_ROUTE_A = 8'h2b;
  localparam logic [7:0] ADDR_ROUTE_B = 8'h2c;
  localparam logic [7:0] ADDR_ROUTE_C = 8'h2d;
  localparam logic [7:0] ADDR_STRAP = 8'h2f;
  localparam logic [7:0] RST_ROUTE_A = 8'h00;
  localparam logic [7:0] RST_ROUTE_B = 8'h81;
  localparam logic [7:0] RST_ROUTE_C = 8'h00;
  localparam logic [7:0] RST_STRAP = 8'h00;
  localparam logic [7:0] WMASK_ROUTE_A = 8'h7d;
  localparam logic [7:0] WMASK_ROUTE_B = 8'h01;
  localparam logic [7:0] FIXED_ROUTE_B = 8'h80;
  localparam logic [7:0] WMASK_ROUTE_C = 8'h5e;
  localparam logic [7:0] G5_MASK_ROUTE_C = 8'h1e;
  localparam logic [7:0] WMASK_STRAP = 8'h23;
  localparam int BIT_PIN30 = 2;
  localparam int BIT_ALT_STRAP = 5;
  localparam int BIT_TEST_STRAP = 1;
  localparam int BIT_CLK_STRAP = 0;
  typedef enum logic [1:0] {
    MFPS_P30_SUPPLY_ON,
    MFPS_P30_ALT_SUPPLY_ON,
    MFPS_P30_GPIO
  } mfps_p30_t;
  typedef struct packed {
    logic [7:0] route_a;
    logic [7:0] route_b;
    logic [7:0] route_c;
    logic [7:0] strap;
    logic strap_done;
    logic [7:0] rdata;
    mfps_p30_t pin30;
  } mfps_state_t;
endpackage

// ---- tb/mfps_host.sv ----
// host model issuing configuration index/data strobes
`timescale 1ns/100ps
`default_nettype none
module mfps_host (
  input wire logic clk_sys,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata
);
  initial begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = 18'h0_0000;
  end
  // one strobe cycle, then idle bus shows inverted values
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {wr, ~wr, a, d};
    @(negedge clk_sys);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// bench for the pin select registers against a reference model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys, arst_n, pok, g5, s_alt, s_test, s_clk, wr, rd;
  logic [7:0] addr, wdata, rdata, ra, rb, rc, rs;
  mfps_pkg::mfps_p30_t p30;
  logic [7:0] m [5];
  logic [7:0] wm [5] = '{8'h7d, 8'h01, 8'h5e, 8'h00, 8'h23};
  int err_count = 0;
  int n_checks = 0;
  int a;
  always #5 clk_sys = ~clk_sys;
  mfps_host i_mfps_host (.clk_sys(clk_sys), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr),
    .cfg_wdata(wdata));
  mfps_pin_select i_mfps_pin_select (.clk_sys(clk_sys), .arst_n(arst_n), .power_ok_reset(pok),
    .gpio_group5_reset(g5), .alt_power_sequence_strap(s_alt), .test_mode_strap(s_test),
    .input_clock_freq_strap(s_clk), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr),
    .cfg_wdata(wdata), .cfg_rdata(rdata), .pin_route_select_a(ra), .pin_route_select_b(rb),
    .pin_route_select_c(rc), .strap_result(rs), .pin30_mode(p30));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic chk_all();
    @(negedge clk_sys);
    chk(ra, m[0]);
    chk(rb, m[1]);
    chk(rc, m[2]);
    chk(rs, m[4]);
    chk({6'h00, p30}, m[2][2] ? 8'h02 : (m[4][5] ? 8'h01 : 8'h00));
  endtask
  task automatic wr_rd(input int i, input logic [7:0] d);
    i_mfps_host.access(1'b1, 8'(8'h2b + i), d);
    if (i != 3) m[i] = (d & wm[i]) | (i == 1 ? 8'h80 : 8'h00);
    i_mfps_host.access(1'b0, 8'(8'h2b + i), 8'h00);
    chk(rdata, m[i]);
  endtask
  task automatic do_reset();
    {s_alt, s_test, s_clk} = 3'($urandom);
    arst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    m = '{8'h00, 8'h81, 8'h00, 8'h00, {2'h0, s_alt, 3'h0, s_test, s_clk}};
    chk_all();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
  initial begin
    {clk_sys, arst_n, pok, g5} = 4'h0;
    void'($urandom(32'h77f9));
    do_reset();
    for (int i = 0; i < 5; i++) wr_rd(i, 8'hff);
    chk_all();
    $display("test reset and masks done");
    repeat (30) begin
      a = $urandom_range(4);
      wr_rd(a, 8'($urandom));
      chk_all();
    end
    $display("test random access done");
    for (int k = 0; k < 4; k++) begin
      wr_rd(4, k[1] ? 8'h20 : 8'h00);
      wr_rd(2, k[0] ? 8'h04 : 8'h00);
      chk_all();
    end
    $display("test pin30 modes done");
    wr_rd(2, 8'h5e);
    wr_rd(4, ~{2'h0, s_alt, 3'h0, s_test, s_clk});
    g5 = 1'b1;
    @(negedge clk_sys);
    g5 = 1'b0;
    m[2] = m[2] & 8'he1;
    chk_all();
    pok = 1'b1;
    @(negedge clk_sys);
    pok = 1'b0;
    m[4] = {m[4][7:2], s_test, s_clk};
    chk_all();
    fork
      i_mfps_host.access(1'b1, 8'h2d, 8'hff);
      begin
        @(negedge clk_sys);
        g5 = 1'b1;
        @(negedge clk_sys);
        g5 = 1'b0;
      end
    join
    m[2] = 8'h40;
    chk_all();
    fork
      i_mfps_host.access(1'b1, 8'h2f, 8'h23);
      begin
        @(negedge clk_sys);
        pok = 1'b1;
        @(negedge clk_sys);
        pok = 1'b0;
      end
    join
    m[4] = {2'h0, 1'b1, 3'h0, s_test, s_clk};
    chk_all();
    i_mfps_host.access(1'b1, 8'h30, 8'hff);
    i_mfps_host.access(1'b0, 8'h30, 8'h00);
    chk(rdata, 8'h00);
    chk_all();
    do_reset();
    $display("test domain resets done");
    test_done();
  end
endmodule
`default_nettype wire
